// ### rtl/adc_ctrl.sv
// Register and sequencing logic for a first-order sigma-delta converter.
// Assumes the analog modulator returns one bit per sample strobe and that
// the bit is asynchronous to the core clock.
//
// Behaviour
// - Modulator is sampled at a fixed 1 MHz regardless of rate.
// - Rate code 0..7 sets conversion time 32 us doubling to 4096 us.
// - Rate code n gives n+5 result bits aligned from bit 15 downward.
// - Input selector field bits 11..8 routes the analog source.
// - Enable bit starts conversions at once; they repeat until cleared.
// - Each completion raises the done flag and updates the result.
// - Done flag interrupts only when its mask bit is set.
// - No busy or valid bit exists; the done flag is the only indicator.
// - Reference output is enabled only while the enable bit is set.
// - Configuration bit 1 set disables dither; cleared leaves it on.
// - Result register is 16-bit read-only; writes have no effect.
// - Done event is a single-cycle pulse setting the flag bit.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl
	import adc_ctrl_pkg::*;
(
	input  wire logic              CORE_CLK_IN,
	input  wire logic              RST_IN,
	input  wire logic              PSEL_IN,
	input  wire logic              PENABLE_IN,
	input  wire logic              PWRITE_IN,
	input  wire logic [ADDR_W-1:0] PADDR_IN,
	input  wire logic [31:0]       PWDATA_IN,
	output logic [31:0]            PRDATA_OUT,
	output logic                   PREADY_OUT,
	output logic                   PSLVERR_OUT,
	input  wire logic              MOD_BIT_IN,
	output logic                   MOD_SAMPLE_OUT,
	output logic [3:0]             SOURCE_SEL_OUT,
	output logic                   DITHER_DISABLE_OUT,
	output logic                   MOD_ENABLE_OUT,
	output logic                   VREF_OUT_EN_OUT,
	output logic                   CONV_DONE_OUT,
	output logic                   IRQ_OUT
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [12:0] samples_for(input logic [2:0] rate);
		samples_for = 13'(BASE_SAMPLES << rate);
	endfunction

	function automatic logic [3:0] drop_bits(input logic [2:0] rate);
		drop_bits = 4'(16 - BASE_BITS - MAX_RATE_CODE + 7) - {1'b0, rate};
	endfunction

	function automatic logic [15:0] keep_mask(input logic [2:0] rate);
		keep_mask = 16'(16'hFFFF << drop_bits(rate));
	endfunction

	// Full scale (every sample high) would overflow into bit 16; it is
	// clamped to the largest code of the chosen resolution instead.
	function automatic logic [15:0] scale(input logic [12:0] ones,
		input logic [2:0] rate);
		logic [16:0] wide;
		wide = 17'({4'h0, ones}) << drop_bits(rate);
		scale = wide[16] ? keep_mask(rate) : wide[15:0];
	endfunction

	function automatic logic at(input logic [ADDR_W-1:0] a,
		input logic [15:0] idx);
		at = (a == ADDR_W'({idx, 2'b00}));
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [15:0] cfg_q;
	logic [15:0] result_q;
	logic [15:0] stat_q;
	logic [15:0] mask_q;
	logic [15:0] rd_stat_q;
	logic [4:0]  div_q;
	logic        mod_s1_q;
	logic        mod_s2_q;
	logic [12:0] samp_cnt_q;
	logic [12:0] ones_q;
	logic        done_q;
	logic        irq_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	logic        en;
	logic [2:0]  rate;
	logic        access;
	logic        commit;
	logic        mapped;
	logic        fire;

	assign en     = cfg_q[CFG_EN_BIT];
	assign rate   = cfg_q[CFG_RATE_LSB +: 3];
	assign access = PSEL_IN && PENABLE_IN;
	assign commit = access && pready_q;
	assign mapped = at(PADDR_IN, IDX_RESULT) || at(PADDR_IN, IDX_CONFIG)
		|| at(PADDR_IN, IDX_IRQ_STAT) || at(PADDR_IN, IDX_IRQ_MASK);
	// A rate lowered while enabled can leave the count past the new end.
	// Ending at the next strobe keeps it from running on until it wraps.
	assign fire   = en && MOD_SAMPLE_OUT
		&& (samp_cnt_q >= samples_for(rate) - 13'h0001);

	// ------------------------------------------------------------------
	// APB slave: one wait state, answer registered
	// ------------------------------------------------------------------
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			rd_stat_q <= IRQ_RESET;
		end else if (access && !pready_q) begin
			pready_q  <= 1'b1;
			pslverr_q <= !mapped;
			rd_stat_q <= IRQ_RESET;
			prdata_q  <= 32'h0000_0000;
			if (!PWRITE_IN) begin
				// Result, configuration, the done flag and the mask are all visible.
				if (at(PADDR_IN, IDX_RESULT))
					prdata_q <= {16'h0000, result_q};
				if (at(PADDR_IN, IDX_CONFIG))
					prdata_q <= {16'h0000, cfg_q};
				if (at(PADDR_IN, IDX_IRQ_STAT)) begin
					prdata_q  <= {16'h0000, stat_q};
					rd_stat_q <= stat_q;
				end
				if (at(PADDR_IN, IDX_IRQ_MASK))
					prdata_q <= {16'h0000, mask_q};
			end
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Configuration and mask registers
	// ------------------------------------------------------------------
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			cfg_q  <= CFG_RESET;
			mask_q <= IRQ_RESET;
		end else if (commit && PWRITE_IN) begin
			if (at(PADDR_IN, IDX_CONFIG))
				cfg_q <= PWDATA_IN[15:0] & CFG_WMASK;
			if (at(PADDR_IN, IDX_IRQ_MASK))
				mask_q <= PWDATA_IN[15:0] & IRQ_WMASK;
		end
	end

	// ------------------------------------------------------------------
	// Sample strobe and modulator bit synchroniser
	// ------------------------------------------------------------------
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			div_q          <= 5'h00;
			MOD_SAMPLE_OUT <= 1'b0;
		end else begin
			div_q <= (div_q == 5'(SAMPLE_CYCLES - 1)) ? 5'h00
				: div_q + 5'h01;
			MOD_SAMPLE_OUT <= (div_q == 5'(SAMPLE_CYCLES - 1));
		end
	end

	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			mod_s1_q <= 1'b0;
			mod_s2_q <= 1'b0;
		end else begin
			mod_s1_q <= MOD_BIT_IN;
			mod_s2_q <= mod_s1_q;
		end
	end

	// ------------------------------------------------------------------
	// Decimation: count ones over the conversion window
	// ------------------------------------------------------------------
	// The result register is updated only here; bus writes never reach it.
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			samp_cnt_q <= 13'h0000;
			ones_q     <= 13'h0000;
			result_q   <= RESULT_RESET;
			done_q     <= 1'b0;
		end else begin
			done_q <= fire;
			if (!en) begin
				samp_cnt_q <= 13'h0000;
				ones_q     <= 13'h0000;
			end else if (fire) begin
				result_q   <= scale(ones_q + {12'h000, mod_s2_q},
					rate);
				samp_cnt_q <= 13'h0000;
				ones_q     <= 13'h0000;
			end else if (MOD_SAMPLE_OUT) begin
				samp_cnt_q <= samp_cnt_q + 13'h0001;
				ones_q     <= ones_q + {12'h000, mod_s2_q};
			end
		end
	end

	// ------------------------------------------------------------------
	// Done flag and interrupt
	// ------------------------------------------------------------------
	// A read clears only the bits it returned, so an event landing during
	// the read survives. Writing a one clears as well. Set beats clear.
	logic [15:0] stat_clr;

	always_comb begin
		stat_clr = IRQ_RESET;
		if (commit && !PWRITE_IN && at(PADDR_IN, IDX_IRQ_STAT))
			stat_clr = rd_stat_q;
		if (commit && PWRITE_IN && at(PADDR_IN, IDX_IRQ_STAT))
			stat_clr = PWDATA_IN[15:0] & IRQ_WMASK;
	end

	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			stat_q <= IRQ_RESET;
		end else begin
			stat_q <= (stat_q & ~stat_clr)
				| (16'(done_q) << IRQ_DONE_BIT);
		end
	end

	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN)
			irq_q <= 1'b0;
		else
			irq_q <= |(stat_q & mask_q);
	end

	// ------------------------------------------------------------------
	// Outputs to the analog side
	// ------------------------------------------------------------------
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			SOURCE_SEL_OUT     <= 4'h0;
			DITHER_DISABLE_OUT <= 1'b0;
			MOD_ENABLE_OUT     <= 1'b0;
			VREF_OUT_EN_OUT    <= 1'b0;
		end else begin
			SOURCE_SEL_OUT     <= cfg_q[CFG_SEL_LSB +: 4];
			DITHER_DISABLE_OUT <= cfg_q[CFG_DITH_BIT];
			MOD_ENABLE_OUT     <= en;
			VREF_OUT_EN_OUT    <= en;
		end
	end

	assign PRDATA_OUT    = prdata_q;
	assign PREADY_OUT    = pready_q;
	assign PSLVERR_OUT   = pslverr_q;
	assign CONV_DONE_OUT = done_q;
	assign IRQ_OUT       = irq_q;

	// ------------------------------------------------------------------
	// Conversion spacing monitor
	// ------------------------------------------------------------------
	// Counts core cycles between completions, so the spacing check does not
	// lean on the sample counter it guards. A configuration write skips the
	// check of the next completion, since the span that straddles the write may be short.
	logic        cfg_wr;
	logic        back_q;
	logic [16:0] conv_cyc_q;

	assign cfg_wr = commit && PWRITE_IN && at(PADDR_IN, IDX_CONFIG);

	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			back_q     <= 1'b0;
			conv_cyc_q <= 17'h00000;
		end else begin
			back_q     <= en && !cfg_wr && (done_q || back_q);
			conv_cyc_q <= (done_q || !en) ? 17'h00001
				: conv_cyc_q + 17'h00001;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	strobe_period_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		MOD_SAMPLE_OUT |=> !MOD_SAMPLE_OUT ##19 MOD_SAMPLE_OUT)
		else $error("sample strobe not every 20 cycles");
	conv_length_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		CONV_DONE_OUT && back_q |->
		conv_cyc_q == 17'(SAMPLE_CYCLES) * {4'h0, samples_for(rate)})
		else $error("conversion time does not match rate code");
	result_align_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		CONV_DONE_OUT |-> (result_q & ~keep_mask($past(rate))) == 16'h0000)
		else $error("result has bits below resolution");
	source_sel_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		SOURCE_SEL_OUT == $past(cfg_q[CFG_SEL_LSB +: 4]))
		else $error("source select does not follow register");
	idle_quiet_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		(!en)[*2] |-> !CONV_DONE_OUT)
		else $error("conversion completed while disabled");
	done_sets_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		CONV_DONE_OUT |=> stat_q[IRQ_DONE_BIT])
		else $error("done pulse did not set flag");
	irq_gate_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		IRQ_OUT |-> $past(stat_q[IRQ_DONE_BIT] && mask_q[IRQ_DONE_BIT]))
		else $error("interrupt raised without unmasked flag");
	vref_follow_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		$rose(en) |=> VREF_OUT_EN_OUT ##0 MOD_ENABLE_OUT)
		else $error("reference output not enabled with converter");
	dither_ctl_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		$fell(cfg_q[CFG_DITH_BIT]) |=> !DITHER_DISABLE_OUT)
		else $error("dither not restored");
	result_ro_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		!done_q && !fire |=> $stable(result_q))
		else $error("result changed outside completion");
	done_pulse_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		CONV_DONE_OUT |=> !CONV_DONE_OUT [*8])
		else $error("done event longer than one cycle");
	cfg_unused_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		commit && PWRITE_IN && at(PADDR_IN, IDX_CONFIG) |=>
		(cfg_q & ~CFG_WMASK) == 16'h0000)
		else $error("unused configuration bits set");

endmodule // adc_ctrl
`default_nettype wire

// ### rtl/adc_ctrl_pkg.sv
// Constants for the sigma-delta converter control block.
// Assumes a 20 MHz core clock and an APB register bus with 32-bit data.
package adc_ctrl_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 50;
	localparam int SAMPLE_PERIOD_NS  = 1000;
	localparam int SAMPLE_CYCLES     = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int BASE_CONV_TIME_US = 32;
	localparam int SAMPLE_RATE_MHZ   = 1;
	localparam int BASE_SAMPLES      = BASE_CONV_TIME_US * SAMPLE_RATE_MHZ;
	localparam int MAX_RATE_CODE     = 7;
	localparam int BASE_BITS         = 5;

	// ------------------------------------------------------------------
	// Register map: printed offsets are indices, byte address is four times
	// ------------------------------------------------------------------
	localparam int          ADDR_W       = 18;
	localparam logic [15:0] IDX_RESULT   = 16'h4900;
	localparam logic [15:0] IDX_CONFIG   = 16'h4902;
	localparam logic [15:0] IDX_IRQ_STAT = 16'h4904;
	localparam logic [15:0] IDX_IRQ_MASK = 16'h4906;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int          CFG_EN_BIT      = 0;
	localparam int          CFG_DITH_BIT    = 1;
	localparam int          CFG_SEL_LSB     = 8;
	localparam int          CFG_RATE_LSB    = 12;
	localparam logic [15:0] CFG_WMASK       = 16'h7F03;
	localparam logic [15:0] CFG_RESET       = 16'h0000;
	localparam logic [15:0] RESULT_RESET    = 16'h0000;
	localparam int          IRQ_DONE_BIT    = 0;
	localparam logic [15:0] IRQ_WMASK       = 16'h0001;
	localparam logic [15:0] IRQ_RESET       = 16'h0000;

endpackage

// ### testbench/adc_mod_model.sv
// Behavioural model of the analog modulator behind the converter control.
// Assumes the control block strobes it and reads one bit per strobe.
`timescale 1ns/1ps
`default_nettype none
module adc_mod_model (
	input  wire logic clk_in,
	input  wire logic enable_in,
	input  wire logic level_in,
	output logic      bit_out
);
	// ------------------------------------------------------------------
	// Output bit
	// ------------------------------------------------------------------
	// A stopped modulator gives no steady level, so the bit toggles to keep
	// a stale value from passing for a real one.
	initial bit_out = 1'b0;
	always @(posedge clk_in) begin
		if (enable_in)
			bit_out <= level_in;
		else
			bit_out <= ~bit_out;
	end
endmodule // adc_mod_model
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the converter control block.
// Assumes a 20 MHz core clock and an APB slave that may add wait states.
`timescale 1ns/1ps
`default_nettype none
module tb
	import adc_ctrl_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        mod_bit;
	logic        samp;
	logic [3:0]  src;
	logic        dith;
	logic        men;
	logic        vref;
	logic        done;
	logic        irq;
	logic        lvl = 1'b1;
	logic        slv;
	logic [31:0] r;
	logic [15:0] e;
	int          n;
	int          mismatches = 0;
	int          checks = 0;

	always #25 clk = ~clk;

	adc_ctrl i_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .MOD_BIT_IN(mod_bit), .MOD_SAMPLE_OUT(samp),
		.SOURCE_SEL_OUT(src), .DITHER_DISABLE_OUT(dith),
		.MOD_ENABLE_OUT(men), .VREF_OUT_EN_OUT(vref),
		.CONV_DONE_OUT(done), .IRQ_OUT(irq));
	adc_mod_model i_mod (.clk_in(clk), .enable_in(men), .level_in(lvl),
		.bit_out(mod_bit));

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic close_out;
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// The request goes out just after a rising edge and stands until the
	// rising edge at which pready is seen high; read data is taken there
	// and only then is the request released.
	task automatic apb(input logic w, input logic [15:0] idx,
		input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			mismatches++;
			close_out();
		end else begin
			r = prdata;
			slv = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// Counts falling edges until the strobe (0) or done pulse (1) shows.
	task automatic gap(input bit which, output int cnt);
		cnt = 0;
		do begin
			@(negedge clk);
			cnt++;
		end while ((which ? done : samp) !== 1'b1 && cnt < 20000);
		if (cnt >= 20000) begin
			mismatches++;
			close_out();
		end
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		apb(0, IDX_RESULT, 0); chk(r, 32'h0);
		apb(0, IDX_CONFIG, 0); chk(r, 32'h0);
		apb(1, IDX_CONFIG, 32'hFFFF);
		apb(0, IDX_CONFIG, 0); chk(r, 32'h7F03);
		chk(dith, 1'b1);
		chk(vref, 1'b1);
		chk(men, 1'b1);
		apb(1, IDX_CONFIG, 0);
		repeat (2) @(negedge clk);
		chk(dith, 1'b0);
		chk(vref, 1'b0);
		chk(men, 1'b0);
		apb(1, IDX_RESULT, 32'h1234);
		apb(0, IDX_RESULT, 0); chk(r, 32'h0);
		apb(0, 16'h0001, 0); chk(slv, 1'b1);
		for (int s = 0; s <= 10; s++) begin
			apb(1, IDX_CONFIG, s << 8);
			repeat (2) @(negedge clk);
			chk(src, s[3:0]);
		end
		apb(1, IDX_IRQ_MASK, 1);
		// Full-scale input, so rates 0 to 3 must clamp to all ones on top.
		for (int k = 0; k <= 3; k++) begin
			apb(1, IDX_CONFIG, (k << 12) | 1);
			gap(1, n);
			gap(1, n); chk(n, 640 << k);
			repeat (2) @(negedge clk);
			chk(irq, 1'b1);
			e = 16'hFFFF << (11 - k);
			apb(0, IDX_RESULT, 0); chk(r, {16'h0, e});
			apb(0, IDX_IRQ_STAT, 0); chk(r, 32'h1);
			apb(1, IDX_CONFIG, 0);
		end
		gap(0, n);
		gap(0, n); chk(n, 20);
		apb(1, IDX_IRQ_MASK, 0);
		lvl <= 1'b0;
		apb(1, IDX_CONFIG, 1);
		gap(1, n);
		gap(1, n);
		@(negedge clk); chk(done, 1'b0);
		repeat (3) @(negedge clk);
		chk(irq, 1'b0);
		apb(0, IDX_RESULT, 0); chk(r, 32'h0);
		apb(0, IDX_IRQ_STAT, 0); chk(r, 32'h1);
		apb(0, IDX_IRQ_STAT, 0); chk(r, 32'h0);
		gap(1, n);
		apb(1, IDX_IRQ_STAT, 32'h1);
		apb(0, IDX_IRQ_STAT, 0); chk(r, 32'h0);
		close_out();
	end
endmodule // tb
`default_nettype wire
